// [bth_header_regs.sv]
// Type-one configuration header registers from 08h to 13h with posted write command selection.
`timescale 1ns/1ps
`include "bth_regs.svh"

// How it works
// - Class top byte reads 06h.
// - Class bits 23:16 read 04h.
// - Programming interface byte reads 00h.
// - Low class byte holds read-only revision.
// - Posted writes default to plain write.
// - Invalidate needs line size power two.
// - Invalidate needs aligned whole-line write.
// - Invalidate needs full lanes and enable.
// - Cache line size read/write, resets 00h.
// - Primary latency timer reads 00h always.
// - Header type reads 01h.
// - Header type bit 7 reads zero.
// - Self-test register reads 00h.
// - Base bits writable only when window enabled.
// - Base requests a 4096-byte window.
// - Base bits 11:4 read zero.
// - Base bit 3 reads zero.
// - Base bits 2:0 read zero.
module bth_header_regs #(
    parameter logic [7:0] SILICON_REVISION = 8'h01 // Arbitrary neutral value.
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Configuration requests from the upstream host.
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // Enables held in other configuration registers.
    input wire logic control_window_enable,
    input wire logic invalidate_enable,
    // Downstream posted write to classify.
    input wire logic wr_valid,
    input wire logic [31:0] wr_addr,
    input wire logic [9:0] wr_len_dw,
    input wire logic [3:0] wr_first_be,
    input wire logic [3:0] wr_last_be,
    output logic wr_cmd_valid,
    output bth_pkg::bth_wcmd_t wr_cmd,
    // Current cache line size for the local bus side.
    output logic [7:0] cache_line_size
);
    import bth_pkg::*;

    logic [1:0] rst_sync;
    logic rst_n;
    bth_state_t state;
    bth_state_t next_state;
    bth_wcmd_t sel_cmd;
    logic [31:0] class_word;
    logic [31:0] hdr_word;
    logic [31:0] base_word;

    // Release of the asynchronous reset through two flip-flops.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Command selector looks at the live line size.
    bth_write_cmd_select u_select (
        .cache_line_size(state.cache_line_size),
        .invalidate_enable(invalidate_enable),
        .wr_addr(wr_addr),
        .wr_len_dw(wr_len_dw),
        .wr_first_be(wr_first_be),
        .wr_last_be(wr_last_be),
        .wr_cmd(sel_cmd)
    );

    // Read images of the three dwords.
    always_comb begin
        class_word[31:24] = `BTH_FUNCTION_CATEGORY_CODE;
        class_word[23:16] = `BTH_SUBCLASS_CODE;
        class_word[15:8] = `BTH_PROGRAMMING_INTERFACE_CODE;
        class_word[7:0] = SILICON_REVISION;
        hdr_word[7:0] = state.cache_line_size;
        hdr_word[15:8] = `BTH_PRIMARY_LATENCY_TIMER_VAL;
        hdr_word[23:16] = `BTH_HEADER_LAYOUT_TYPE_VAL;
        hdr_word[31:24] = `BTH_SELF_TEST_CONTROL_VAL;
        if (control_window_enable) begin
            base_word[`BTH_BASE_ADDR_MSB:`BTH_BASE_ADDR_LSB] = state.base_addr;
        end else begin
            base_word[`BTH_BASE_ADDR_MSB:`BTH_BASE_ADDR_LSB] = '0;
        end
        base_word[11:0] = `BTH_BASE_LOW_BITS;
    end

    // Next state: configuration access, then posted write decision.
    always_comb begin
        next_state = state;
        next_state.cfg_ack = 1'b0;
        next_state.wr_cmd_valid = 1'b0;
        if (cfg_req) begin
            next_state.cfg_ack = 1'b1;
            next_state.cfg_rdata = 32'h0000_0000;
            if (!cfg_write) begin
                case (cfg_addr & 8'hFC)
                    `BTH_OFF_CLASS_AND_REVISION: begin
                        next_state.cfg_rdata = class_word;
                    end
                    `BTH_OFF_HDR_WORD: begin
                        next_state.cfg_rdata = hdr_word;
                    end
                    `BTH_OFF_CONTROL_WINDOW_BASE: begin
                        next_state.cfg_rdata = base_word;
                    end
                    default: begin
                        next_state.cfg_rdata = 32'h0000_0000;
                    end
                endcase
            end else begin
                case (cfg_addr & 8'hFC)
                    `BTH_OFF_HDR_WORD: begin
                        if (cfg_be[0]) begin
                            next_state.cache_line_size = cfg_wdata[7:0];
                        end
                    end
                    `BTH_OFF_CONTROL_WINDOW_BASE: begin
                        // twenty address bits, gated by enable.
                        if (control_window_enable) begin
                            if (cfg_be[1]) begin
                                next_state.base_addr[3:0] = cfg_wdata[15:12];
                            end
                            if (cfg_be[2]) begin
                                next_state.base_addr[11:4] = cfg_wdata[23:16];
                            end
                            if (cfg_be[3]) begin
                                next_state.base_addr[19:12] = cfg_wdata[31:24];
                            end
                        end
                    end
                    default: begin
                        next_state.base_addr = state.base_addr;
                    end
                endcase
            end
        end
        if (wr_valid) begin
            next_state.wr_cmd_valid = 1'b1;
            next_state.wr_cmd = sel_cmd;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state.cache_line_size <= `BTH_CACHE_LINE_SIZE_RST;
            state.base_addr <= 20'(`BTH_CONTROL_WINDOW_BASE_RST >> `BTH_BASE_ADDR_LSB);
            state.cfg_ack <= 1'b0;
            state.cfg_rdata <= 32'h0000_0000;
            state.wr_cmd_valid <= 1'b0;
            state.wr_cmd <= BTH_PLAIN_MEMORY_WRITE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state register.
    assign cfg_ack = state.cfg_ack;
    assign cfg_rdata = state.cfg_rdata;
    assign wr_cmd_valid = state.wr_cmd_valid;
    assign wr_cmd = state.wr_cmd;
    assign cache_line_size = state.cache_line_size;
endmodule

// [bth_header_regs_monitor.sv]
// Checker of the type-one header register bank ports.
`timescale 1ns/1ps
module bth_header_regs_monitor (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic resetn,
    // Configuration requests and answers.
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    // Enables, posted writes and line size.
    input wire logic control_window_enable,
    input wire logic invalidate_enable,
    input wire logic wr_valid,
    input wire logic [31:0] wr_addr,
    input wire logic [3:0] wr_first_be,
    input wire logic [3:0] wr_last_be,
    input wire logic wr_cmd_valid,
    input wire bth_pkg::bth_wcmd_t wr_cmd,
    input wire logic [7:0] cache_line_size
);
    import bth_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Line size writes, and posted writes that may be invalidating.
    wire logic cls_wr = cfg_req && cfg_write && cfg_addr[7:2] == 6'h03 && cfg_be[0];
    wire logic inv_ok = invalidate_enable && &wr_first_be && &wr_last_be && wr_addr[1:0] == 2'h0;
    // A read request to one dword offset.
    sequence s_rd(logic [5:0] dw);
        cfg_req && !cfg_write && cfg_addr[7:2] == dw;
    endsequence
    a_ack_next: assert property (cfg_req |=> cfg_ack) else $error("No ack after request.");
    a_class_fixed: assert property (s_rd(6'h02) |=> cfg_rdata[31:8] == 24'h060400)
        else $error("Class bytes wrong.");
    a_hdr_fixed: assert property (s_rd(6'h03) |=> cfg_rdata == {24'h000100, cache_line_size})
        else $error("Header dword wrong.");
    a_base_low: assert property (s_rd(6'h04) |=> cfg_rdata[11:0] == 12'h000)
        else $error("Base low bits not zero.");
    a_base_gate: assert property (s_rd(6'h04) ##0 !control_window_enable |=> cfg_rdata == 32'h0)
        else $error("Base visible while disabled.");
    a_cls_write: assert property (cls_wr |=> cache_line_size == $past(cfg_wdata[7:0]))
        else $error("Line size not written.");
    a_cls_keep: assert property (!cls_wr |=> $stable(cache_line_size)) else $error("Line size changed.");
    a_cmd_next: assert property (wr_valid |=> wr_cmd_valid) else $error("No command decision.");
    a_cls_pow2: assert property (wr_valid && !$onehot(cache_line_size) |=> wr_cmd == BTH_PLAIN_MEMORY_WRITE)
        else $error("Invalidate with bad line size.");
    a_inv_needs: assert property (wr_cmd_valid && wr_cmd == BTH_INVALIDATING_MEMORY_WRITE |-> $past(inv_ok))
        else $error("Invalidate without lanes or enable.");
endmodule
bind bth_header_regs bth_header_regs_monitor u_bth_header_regs_monitor (.core_clk, .resetn, .cfg_req, .cfg_write,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .control_window_enable, .invalidate_enable, .wr_valid,
    .wr_addr, .wr_first_be, .wr_last_be, .wr_cmd_valid, .wr_cmd, .cache_line_size);

// [bth_host_model.sv]
// Upstream host model that issues configuration requests.
`timescale 1ns/1ps
module bth_host_model (
    // Clock.
    input wire logic core_clk,
    // Request lines.
    output logic cfg_req,
    output logic cfg_write,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    // Answer lines.
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    // The bus is idle at time zero.
    initial {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} = '0;
    // One request, taken at the next edge and answered one edge later.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] rd, output logic ak);
        @(posedge core_clk);
        {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, w, a, be, d};
        @(posedge core_clk);
        // Released lines show the inverse of the last value, never a stale copy.
        {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} <= {1'b0, ~w, ~a, ~be, ~d};
        // The answer stands from the taking edge and is read at the edge that follows.
        @(posedge core_clk);
        ak = cfg_ack;
        rd = cfg_rdata;
    endtask
endmodule

// [bth_pkg.sv]
// Types shared by the type-one header register bank.
package bth_pkg;

    // Command chosen for a forwarded downstream posted write.
    typedef enum logic {
        BTH_PLAIN_MEMORY_WRITE,
        BTH_INVALIDATING_MEMORY_WRITE
    } bth_wcmd_t;

    // Whole state of the register bank top.
    typedef struct packed {
        logic [7:0] cache_line_size;
        logic [19:0] base_addr;
        logic cfg_ack;
        logic [31:0] cfg_rdata;
        logic wr_cmd_valid;
        bth_wcmd_t wr_cmd;
    } bth_state_t;

endpackage

// [bth_regs.svh]
// Offsets, field positions, reset values and fixed codes of the type-one header registers.
`ifndef BTH_REGS_SVH
`define BTH_REGS_SVH

// Dword-aligned configuration offsets.
`define BTH_OFF_CLASS_AND_REVISION 8'h08
`define BTH_OFF_HDR_WORD 8'h0C
`define BTH_OFF_CONTROL_WINDOW_BASE 8'h10

// Byte offsets of the four byte registers packed into the 0Ch dword.
`define BTH_OFF_CACHE_LINE_SIZE 8'h0C
`define BTH_OFF_PRIMARY_LATENCY_TIMER 8'h0D
`define BTH_OFF_HEADER_LAYOUT_TYPE 8'h0E
`define BTH_OFF_SELF_TEST_CONTROL 8'h0F

// Fixed class code fields.
`define BTH_FUNCTION_CATEGORY_CODE 8'h06
`define BTH_SUBCLASS_CODE 8'h04
`define BTH_PROGRAMMING_INTERFACE_CODE 8'h00

// Reset and fixed values of the byte registers.
`define BTH_CACHE_LINE_SIZE_RST 8'h00
`define BTH_PRIMARY_LATENCY_TIMER_VAL 8'h00
`define BTH_HEADER_LAYOUT_TYPE_VAL 8'h01
`define BTH_SELF_TEST_CONTROL_VAL 8'h00

// Control window base layout.
`define BTH_CONTROL_WINDOW_BASE_RST 32'h0000_0000
`define BTH_BASE_ADDR_MSB 31
`define BTH_BASE_ADDR_LSB 12
`define BTH_BASE_ADDR_BITS 20
`define BTH_BASE_LOW_BITS 12'h000

`endif

// [bth_write_cmd_select.sv]
// Chooses a plain or an invalidating memory write for one downstream posted write.
`timescale 1ns/1ps

module bth_write_cmd_select (
    // Cache line setup.
    input wire logic [7:0] cache_line_size,
    input wire logic invalidate_enable,
    // Posted write description.
    input wire logic [31:0] wr_addr,
    input wire logic [9:0] wr_len_dw,
    input wire logic [3:0] wr_first_be,
    input wire logic [3:0] wr_last_be,
    // Decision.
    output bth_pkg::bth_wcmd_t wr_cmd
);
    import bth_pkg::*;

    logic line_size_ok;
    logic line_aligned;
    logic whole_line;
    logic lanes_full;
    logic [7:0] line_mask;

    assign line_mask = cache_line_size - 8'h01;
    assign line_size_ok = (cache_line_size != 8'h00) && ((cache_line_size & line_mask) == 8'h00);

    assign line_aligned = (wr_addr[1:0] == 2'h0) && ((wr_addr[9:2] & line_mask) == 8'h00);
    assign whole_line = wr_len_dw >= {2'h0, cache_line_size};

    assign lanes_full = (wr_first_be == 4'hF) && (wr_last_be == 4'hF);

    // plain write unless every condition holds.
    always_comb begin
        if (line_size_ok && line_aligned && whole_line && lanes_full && invalidate_enable) begin
            wr_cmd = BTH_INVALIDATING_MEMORY_WRITE;
        end else begin
            wr_cmd = BTH_PLAIN_MEMORY_WRITE;
        end
    end
endmodule

// [test_bth_header_regs.sv]
// Testbench of the type-one header register bank.
`timescale 1ns/1ps
module test_bth_header_regs;
    import bth_pkg::*;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary revision code.
    logic core_clk, resetn, cfg_req, cfg_write, cfg_ack, control_window_enable, invalidate_enable;
    logic wr_valid, wr_cmd_valid;
    logic [7:0] cfg_addr, cache_line_size;
    logic [3:0] cfg_be, wr_first_be, wr_last_be;
    logic [31:0] cfg_wdata, cfg_rdata, wr_addr;
    logic [9:0] wr_len_dw;
    bth_wcmd_t wr_cmd;
    logic [7:0] cv [5] = '{8'hFF, 8'h0C, 8'h01, 8'h02, 8'h80};
    int err_total = 0;
    int n_compared = 0;
    // The 40 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    bth_header_regs #(.SILICON_REVISION(REV)) u_bth_header_regs (.core_clk, .resetn, .cfg_req, .cfg_write,
        .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .control_window_enable, .invalidate_enable, .wr_valid,
        .wr_addr, .wr_len_dw, .wr_first_be, .wr_last_be, .wr_cmd_valid, .wr_cmd, .cache_line_size);
    bth_host_model u_bth_host_model (.core_clk, .cfg_req, .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack,
        .cfg_rdata);
    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One configuration access with its expected answer.
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                       input logic [31:0] exp);
        logic [31:0] rd;
        logic ak;
        u_bth_host_model.xfer(w, a, be, d, rd, ak);
        chk("cfg_ack", 32'h1, {31'h0, ak});
        chk("cfg_rdata", exp, rd);
    endtask
    // One posted write to classify, decided one edge after it is taken.
    task automatic post(input logic [31:0] a, input logic [9:0] n, input logic [3:0] f, input logic [3:0] l,
                        input bth_wcmd_t exp);
        @(posedge core_clk);
        {wr_valid, wr_addr, wr_len_dw, wr_first_be, wr_last_be} <= {1'b1, a, n, f, l};
        @(posedge core_clk);
        wr_valid <= 1'b0;
        // The decision stands from the taking edge and is read at the edge that follows.
        @(posedge core_clk);
        chk("wr_cmd_valid", 32'h1, {31'h0, wr_cmd_valid});
        chk("wr_cmd", {31'h0, exp}, {31'h0, wr_cmd});
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end
    // Reset, then the register and posted write sequences.
    initial begin
        resetn = 1'b0;
        {control_window_enable, invalidate_enable, wr_valid, wr_addr, wr_len_dw, wr_first_be, wr_last_be} = '0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        acc(1'b1, 8'h08, 4'hF, 32'hFFFFFFFF, 32'h0);
        acc(1'b0, 8'h08, 4'hF, 32'h0, {24'h060400, REV});
        acc(1'b0, 8'h0C, 4'hF, 32'h0, 32'h00010000);
        post(32'h0, 10'd16, 4'hF, 4'hF, BTH_PLAIN_MEMORY_WRITE);
        acc(1'b1, 8'h0C, 4'hF, 32'hFFFFFF10, 32'h0);
        acc(1'b0, 8'h0C, 4'hF, 32'h0, 32'h00010010);
        chk("cache_line_size", 32'h10, {24'h0, cache_line_size});
        @(posedge core_clk) invalidate_enable <= 1'b1;
        post(32'h40, 10'd16, 4'hF, 4'hF, BTH_INVALIDATING_MEMORY_WRITE);
        post(32'h44, 10'd16, 4'hF, 4'hF, BTH_PLAIN_MEMORY_WRITE);
        post(32'h40, 10'd15, 4'hF, 4'hF, BTH_PLAIN_MEMORY_WRITE);
        post(32'h40, 10'd16, 4'hE, 4'hF, BTH_PLAIN_MEMORY_WRITE);
        post(32'h40, 10'd16, 4'hF, 4'h7, BTH_PLAIN_MEMORY_WRITE);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, 8'h0C, 4'h1, {24'h0, cv[i]}, 32'h0);
            post(32'h0, {2'b0, cv[i]}, 4'hF, 4'hF, bth_wcmd_t'($onehot(cv[i])));
        end
        @(posedge core_clk) invalidate_enable <= 1'b0;
        post(32'h0, 10'd128, 4'hF, 4'hF, BTH_PLAIN_MEMORY_WRITE);
        acc(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0);
        acc(1'b0, 8'h10, 4'hF, 32'h0, 32'h0);
        @(posedge core_clk) control_window_enable <= 1'b1;
        acc(1'b0, 8'h10, 4'hF, 32'h0, 32'h0);
        acc(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF, 32'h0);
        acc(1'b0, 8'h10, 4'hF, 32'h0, 32'hFFFFF000);
        acc(1'b1, 8'h10, 4'h4, 32'h0, 32'h0);
        acc(1'b0, 8'h10, 4'hF, 32'h0, 32'hFF00F000);
        @(posedge core_clk) control_window_enable <= 1'b0;
        acc(1'b0, 8'h10, 4'hF, 32'h0, 32'h0);
        give_verdict();
    end
endmodule
